// File: design/tcmp_pkg.sv
// constants shared by the compare/pwm channel files
// assumes a single 20 MHz clock domain and plain control ports
package tcmp_pkg;
  localparam int          CNT_W          = 16;
  localparam int          NUM_CH         = 4;
  // mode select field codes (high:low)
  localparam logic [1:0]  MODE_UNBUF     = 2'h1;
  localparam logic [1:0]  MODE_BUF       = 2'h2;
  // edge/level field codes (high:low)
  localparam logic [1:0]  EL_NONE        = 2'h0;
  localparam logic [1:0]  EL_TOGGLE      = 2'h1;
  localparam logic [1:0]  EL_CLEAR       = 2'h2;
  localparam logic [1:0]  EL_SET         = 2'h3;
  // values after reset
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [15:0] PERIOD_RST     = 16'hffff;
  localparam logic [15:0] VALUE_RST      = 16'h0000;
  localparam logic [2:0]  PRESCALE_RST   = 3'h0;
  localparam logic [5:0]  PRE_CNT_RST    = 6'h00;
  localparam logic        HALT_RST       = 1'b1;
  localparam int          SYNC_STAGES    = 2;
endpackage

// File: design/tcmp_reset_sync.sv
// reset release synchroniser
// assumes nrst may drop at any time; release is clocked by clk
`timescale 1ns/1ps
`default_nettype none
module tcmp_reset_sync (
  input  wire logic clk,
  input  wire logic nrst,
  output logic      rst_n_sync
);
  logic [tcmp_pkg::SYNC_STAGES-1:0] sync_q;
  logic [tcmp_pkg::SYNC_STAGES-1:0] sync_d;

  // shift a one in after release
  always_comb begin
    sync_d = {sync_q[tcmp_pkg::SYNC_STAGES-2:0], 1'b1};
  end

  // asserts at once, releases two edges later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign rst_n_sync = sync_q[tcmp_pkg::SYNC_STAGES-1];
endmodule
`default_nettype wire

// File: design/tcmp_channel.sv
// one compare/pwm output stage: acts on a match and on counter wrap
// assumes match and wrap are single-cycle strobes from the counter
`timescale 1ns/1ps
`default_nettype none
module tcmp_channel (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       active,
  input  wire logic [1:0] edge_level,
  input  wire logic       toggle_on_wrap_bit,
  input  wire logic       full_duty_bit,
  input  wire logic       match,
  input  wire logic       wrap,
  output logic            pin_q
);
  logic pin_d;

  // compare action applied after wrap toggle; full duty holds high unless wrap toggle is on
  always_comb begin
    pin_d = pin_q;
    if (active) begin
      if (wrap && toggle_on_wrap_bit) begin
        pin_d = ~pin_d;
      end
      if (match) begin
        case (edge_level)
          tcmp_pkg::EL_TOGGLE: pin_d = ~pin_d;
          tcmp_pkg::EL_CLEAR:  pin_d = 1'b0;
          tcmp_pkg::EL_SET:    pin_d = 1'b1;
          default:             pin_d = pin_d;
        endcase
      end
      if (full_duty_bit && !toggle_on_wrap_bit) begin
        pin_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end
endmodule
`default_nettype wire

// File: design/tcmp_top.sv
// four-channel 16-bit compare/pwm timer core with paired buffering
// assumes control ports are synchronous levels; value writes are strobes
`timescale 1ns/1ps
`default_nettype none
module tcmp_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        counter_halt_bit,
  input  wire logic        counter_reset,
  input  wire logic [2:0]  prescale_sel,
  input  wire logic        wrap_irq_en,
  input  wire logic        wrap_flag_clr,
  input  wire logic        period_wr,
  input  wire logic [15:0] period_wdata,
  input  wire logic [3:0]  chan_value_wr,
  input  wire logic [15:0] chan_value_wdata,
  input  wire logic [7:0]  mode_sel,
  input  wire logic [7:0]  edge_level_sel,
  input  wire logic [3:0]  toggle_on_wrap_bit,
  input  wire logic [3:0]  full_duty_bit,
  input  wire logic [3:0]  chan_irq_en,
  input  wire logic [3:0]  chan_flag_clr,
  output logic [15:0]      count_q,
  output logic             wrap_flag_q,
  output logic             wrap_irq_q,
  output logic [3:0]       chan_flag_q,
  output logic [3:0]       chan_irq_q,
  output logic [3:0]       chan_pin_q,
  output logic [3:0]       chan_pin_oe_n_q
);
  logic        rst_n;
  logic [15:0] count_d;
  logic [5:0]  pre_q;
  logic [5:0]  pre_d;
  logic [15:0] period_q;
  logic [15:0] period_d;
  logic [15:0] value_q [tcmp_pkg::NUM_CH];
  logic [15:0] value_d [tcmp_pkg::NUM_CH];
  logic [1:0]  odd_last_q;
  logic [1:0]  odd_last_d;
  logic [1:0]  odd_active_q;
  logic [1:0]  odd_active_d;
  logic        wrap_flag_d;
  logic        wrap_irq_d;
  logic [3:0]  chan_flag_d;
  logic [3:0]  chan_irq_d;
  logic [3:0]  pin_oe_n_d;
  logic        tick;
  logic        wrap;
  logic [3:0]  match;
  logic [3:0]  active;
  logic [1:0]  link;
  logic [3:0]  raw_pin;
  logic [1:0]  ch_el [tcmp_pkg::NUM_CH];

  tcmp_reset_sync u_rst (
    .clk        (clk),
    .nrst       (nrst),
    .rst_n_sync (rst_n)
  );

  // mode decode: link bit wins over the low bit
  function automatic logic is_linked(input logic [1:0] mode);
    is_linked = mode[1];
  endfunction

  function automatic logic is_compare(input logic [1:0] mode);
    is_compare = mode[1] | mode[0];
  endfunction

  // prescaler: divide by 2^sel, sel 7 divides by 64 like sel 6
  function automatic logic pre_done(input logic [5:0] cnt, input logic [2:0] sel);
    logic [5:0] lim;
    lim = 6'((7'h01 << sel) - 7'h01);
    pre_done = (cnt >= lim);
  endfunction

  assign link[0] = is_linked(mode_sel[1:0]);
  assign link[1] = is_linked(mode_sel[5:4]);

  // counter and prescaler; wrap is one tick past the period value
  always_comb begin
    tick    = !counter_halt_bit && pre_done(pre_q, prescale_sel);
    wrap    = tick && (count_q == period_q);
    pre_d   = pre_q;
    count_d = count_q;
    if (counter_reset) begin
      pre_d   = tcmp_pkg::PRE_CNT_RST;
      count_d = tcmp_pkg::CNT_RST;
    end else if (!counter_halt_bit) begin
      pre_d = tick ? tcmp_pkg::PRE_CNT_RST : 6'(pre_q + 6'h01);
      if (tick) begin
        count_d = wrap ? tcmp_pkg::CNT_RST : 16'(count_q + 16'h0001);
      end
    end
  end

  // matches against the counter value present on the step just taken
  always_comb begin
    for (int i = 0; i < tcmp_pkg::NUM_CH; i++) begin
      match[i] = 1'b0;
    end
    // even channels compare against whichever pair register is in charge
    for (int p = 0; p < 2; p++) begin
      if (link[p]) begin
        match[2*p] = tick && (count_q == (odd_active_q[p] ? value_q[2*p+1] : value_q[2*p]));
      end else begin
        match[2*p]   = tick && (count_q == value_q[2*p]);
        match[2*p+1] = tick && (count_q == value_q[2*p+1]);
      end
    end
  end

  // register updates; unbuffered writes go straight in
  always_comb begin
    period_d     = period_wr ? period_wdata : period_q;
    odd_last_d   = odd_last_q;
    odd_active_d = odd_active_q;
    for (int i = 0; i < tcmp_pkg::NUM_CH; i++) begin
      value_d[i] = chan_value_wr[i] ? chan_value_wdata : value_q[i];
    end
    for (int p = 0; p < 2; p++) begin
      if (!link[p]) begin
        odd_last_d[p]   = 1'b0;
        odd_active_d[p] = 1'b0; // even register leads on link
      end else begin
        if (chan_value_wr[2*p+1]) begin
          odd_last_d[p] = 1'b1;
        end else if (chan_value_wr[2*p]) begin
          odd_last_d[p] = 1'b0;
        end
        if (wrap) begin
          odd_active_d[p] = odd_last_d[p];
        end
      end
    end
  end

  // per-channel activity and configuration; odd control ignored when linked
  always_comb begin
    for (int i = 0; i < tcmp_pkg::NUM_CH; i++) begin
      active[i] = is_compare(mode_sel[2*i +: 2]);
      ch_el[i]  = edge_level_sel[2*i +: 2];
    end
    active[1] = active[1] && !link[0];
    active[3] = active[3] && !link[1];
  end

  for (genvar g = 0; g < tcmp_pkg::NUM_CH; g++) begin : g_ch
    tcmp_channel u_ch (
      .clk                (clk),
      .rst_n              (rst_n),
      .active             (active[g]),
      .edge_level         (ch_el[g]),
      .toggle_on_wrap_bit (toggle_on_wrap_bit[g]),
      .full_duty_bit      (full_duty_bit[g]),
      .match              (match[g]),
      .wrap               (wrap),
      .pin_q              (raw_pin[g])
    );
  end

  // flags: hardware set beats software clear
  always_comb begin
    wrap_flag_d = wrap || (wrap_flag_q && !wrap_flag_clr);
    wrap_irq_d  = wrap_flag_d && wrap_irq_en;
    for (int i = 0; i < tcmp_pkg::NUM_CH; i++) begin
      chan_flag_d[i] = (match[i] && active[i]) || (chan_flag_q[i] && !chan_flag_clr[i]);
      chan_irq_d[i]  = chan_flag_d[i] && chan_irq_en[i];
    end
    // output enable low while the timer drives; odd pin freed on link
    for (int i = 0; i < tcmp_pkg::NUM_CH; i++) begin
      pin_oe_n_d[i] = !active[i];
    end
    pin_oe_n_d[1] = pin_oe_n_d[1] || link[0];
    pin_oe_n_d[3] = pin_oe_n_d[3] || link[1];
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q         <= tcmp_pkg::CNT_RST;
      pre_q           <= tcmp_pkg::PRE_CNT_RST;
      period_q        <= tcmp_pkg::PERIOD_RST;
      odd_last_q      <= '0;
      odd_active_q    <= '0;
      wrap_flag_q     <= 1'b0;
      wrap_irq_q      <= 1'b0;
      chan_flag_q     <= '0;
      chan_irq_q      <= '0;
      chan_pin_oe_n_q <= 4'hf;
      for (int i = 0; i < tcmp_pkg::NUM_CH; i++) begin
        value_q[i] <= tcmp_pkg::VALUE_RST;
      end
    end else begin
      count_q         <= count_d;
      pre_q           <= pre_d;
      period_q        <= period_d;
      odd_last_q      <= odd_last_d;
      odd_active_q    <= odd_active_d;
      wrap_flag_q     <= wrap_flag_d;
      wrap_irq_q      <= wrap_irq_d;
      chan_flag_q     <= chan_flag_d;
      chan_irq_q      <= chan_irq_d;
      chan_pin_oe_n_q <= pin_oe_n_d;
      for (int i = 0; i < tcmp_pkg::NUM_CH; i++) begin
        value_q[i] <= value_d[i];
      end
    end
  end

  // pin level already registered inside each channel stage
  assign chan_pin_q = raw_pin;
endmodule
`default_nettype wire

// File: tb/tcmp_pin_load.sv
// load on the four channel pins, pulled down when released
// assumes oe_n low means the timer drives the pin
`timescale 1ns/1ps
`default_nettype none
module tcmp_pin_load (
  input  wire logic [3:0] pin_q,
  input  wire logic [3:0] oe_n,
  output logic      [3:0] level
);
  // released pins fall to the pull-down, never keep the old level
  assign level = pin_q & ~oe_n;
endmodule
`default_nettype wire

// File: tb/tcmp_top_sva.sv
// checker for the compare timer ports
// assumes one clock; only top ports are seen
`timescale 1ns/1ps
`default_nettype none
module tcmp_top_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        counter_halt_bit,
  input wire logic        counter_reset,
  input wire logic [2:0]  prescale_sel,
  input wire logic        wrap_irq_en,
  input wire logic        period_wr,
  input wire logic [15:0] period_wdata,
  input wire logic [3:0]  chan_value_wr,
  input wire logic [15:0] chan_value_wdata,
  input wire logic [7:0]  mode_sel,
  input wire logic [7:0]  edge_level_sel,
  input wire logic [3:0]  toggle_on_wrap_bit,
  input wire logic [3:0]  full_duty_bit,
  input wire logic [15:0] count_q,
  input wire logic        wrap_flag_q,
  input wire logic        wrap_irq_q,
  input wire logic [3:0]  chan_flag_q,
  input wire logic [3:0]  chan_pin_q,
  input wire logic [3:0]  chan_pin_oe_n_q
);
  logic [15:0] per_q;
  logic [15:0] v0_q;
  logic        run;
  logic        hit0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // shadow copies of period and channel 0 value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_q <= tcmp_pkg::PERIOD_RST;
      v0_q  <= tcmp_pkg::VALUE_RST;
    end else begin
      if (period_wr) per_q <= period_wdata;
      if (chan_value_wr[0]) v0_q <= chan_value_wdata;
    end
  end
  // step every clock only; a same-cycle write makes the hit ambiguous
  assign run  = !counter_halt_bit && !counter_reset && prescale_sel == 3'h0;
  assign hit0 = run && count_q == v0_q && !chan_value_wr[0] && mode_sel[1:0] == tcmp_pkg::MODE_UNBUF;
  cmp_set_pin_a: assert property (hit0 && edge_level_sel[1:0] == tcmp_pkg::EL_SET |=> chan_pin_q[0])
    else $error("set on compare missing");
  cmp_clr_pin_a: assert property (hit0 && edge_level_sel[1:0] == tcmp_pkg::EL_CLEAR && !full_duty_bit[0]
    |=> !chan_pin_q[0])
    else $error("clear on compare missing");
  match_flag_a: assert property (hit0 |=> chan_flag_q[0])
    else $error("match flag not set");
  wrap_roll_a: assert property (run && count_q == per_q |=> wrap_flag_q && count_q == 16'h0000)
    else $error("wrap did not roll to zero");
  // request and flag load on the same edge; a clear pulse drops both together
  wrap_irq_a: assert property (wrap_flag_q && $past(wrap_irq_en) |-> wrap_irq_q)
    else $error("wrap request missing");
  pair01_gpio_a: assert property (mode_sel[1] [*2] |-> chan_pin_oe_n_q[1])
    else $error("channel 1 pin still driven");
  pair23_gpio_a: assert property (mode_sel[5] [*2] |-> chan_pin_oe_n_q[3])
    else $error("channel 3 pin still driven");
  full_duty_a: assert property (full_duty_bit[2] && !toggle_on_wrap_bit[2] && mode_sel[5:4] != 2'h0
    |=> chan_pin_q[2])
    else $error("full duty not high");
  cover property (hit0 ##1 chan_flag_q[0]);
  cover property ($rose(wrap_flag_q));
  cover property ($rose(chan_pin_oe_n_q[1]));
endmodule
bind tcmp_top tcmp_top_sva chk (.clk(clk), .nrst(nrst), .counter_halt_bit(counter_halt_bit),
  .counter_reset(counter_reset), .prescale_sel(prescale_sel), .wrap_irq_en(wrap_irq_en), .period_wr(period_wr),
  .period_wdata(period_wdata), .chan_value_wr(chan_value_wr), .chan_value_wdata(chan_value_wdata),
  .mode_sel(mode_sel), .edge_level_sel(edge_level_sel), .toggle_on_wrap_bit(toggle_on_wrap_bit),
  .full_duty_bit(full_duty_bit), .count_q(count_q), .wrap_flag_q(wrap_flag_q), .wrap_irq_q(wrap_irq_q),
  .chan_flag_q(chan_flag_q), .chan_pin_q(chan_pin_q), .chan_pin_oe_n_q(chan_pin_oe_n_q));
`default_nettype wire

// File: tb/timer_compare_pwm_channels_bench.sv
// bench: drives the compare timer, checks it against a cycle model
// assumes design files, pin load and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module timer_compare_pwm_channels_bench;
  logic        clk = 1'b0, nrst = 1'b0, halt = 1'b1, crst = 1'b0, wclr = 1'b0, pwr = 1'b0, go = 1'b0;
  logic [15:0] pdat = 16'h0000, vdat = 16'h0000, count_q;
  logic [3:0]  vwr = 4'h0, tov = 4'h0, full = 4'h0, fclr = 4'h0, lvl, oe = 4'hf, ien = 4'hf;
  logic        ten = 1'b1;
  logic [7:0]  mode = 8'h00, el = 8'h00;
  logic        wrap_flag_q, wrap_irq_q;
  logic [3:0]  chan_flag_q, chan_irq_q, chan_pin_q, chan_pin_oe_n_q;
  int          err_count = 0, compares = 0, cyc = 0, seed = 70529, cnt = 0, per = 'hffff, v[4];
  bit [3:0]    pin, cf, ci;
  bit          sel[2], lw[2], wf, wi;
  tcmp_top uut (.clk(clk), .nrst(nrst), .counter_halt_bit(halt), .counter_reset(crst), .prescale_sel(3'h0),
    .wrap_irq_en(ten), .wrap_flag_clr(wclr), .period_wr(pwr), .period_wdata(pdat), .chan_value_wr(vwr),
    .chan_value_wdata(vdat), .mode_sel(mode), .edge_level_sel(el), .toggle_on_wrap_bit(tov),
    .full_duty_bit(full), .chan_irq_en(ien), .chan_flag_clr(fclr), .count_q(count_q),
    .wrap_flag_q(wrap_flag_q), .wrap_irq_q(wrap_irq_q), .chan_flag_q(chan_flag_q), .chan_irq_q(chan_irq_q),
    .chan_pin_q(chan_pin_q), .chan_pin_oe_n_q(chan_pin_oe_n_q));
  tcmp_pin_load load (.pin_q(chan_pin_q), .oe_n(chan_pin_oe_n_q), .level(lvl));
  always #25 clk = ~clk;
  task automatic print_verdict();
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] rnd();
    return 16'h0028 + 16'($random(seed) & 32'h7f);  // stays 40..167, clear of write points
  endfunction
  task automatic wr(logic [3:0] ch, logic [15:0] d);
    @(negedge clk);
    vwr = ch;
    vdat = d;
    @(negedge clk);
    vwr = 4'h0;
  endtask
  // bounded wait for a counter value
  // a wait that runs out is a failure, not a silent skip
  task automatic to_count(int c);
    bit seen;
    seen = 1'b0;
    repeat (600) begin
      @(negedge clk);
      if (count_q === 16'(c)) begin
        seen = 1'b1;
        break;
      end
    end
    if (!seen) begin
      err_count++;
      print_verdict();
    end
  endtask
  // cycle model: wrap toggle first, then compare, pair select at wrap
  always @(posedge clk) if (nrst) begin
    bit tk, w, lk, act;
    int p, a;
    tk = !halt && !crst;
    w = tk && cnt == per;
    for (int i = 0; i < 4; i++) begin
      p = i / 2;
      lk = mode[4*p+1];
      act = mode[2*i +: 2] != 2'h0 && !(i % 2 == 1 && lk);
      a = (lk && sel[p] && i % 2 == 0) ? v[i+1] : v[i];
      if (act) begin
        if (w && tov[i]) pin[i] = !pin[i];
        if (tk && cnt == a) case (el[2*i +: 2])
          2'h1: pin[i] = !pin[i];
          2'h2: pin[i] = 1'b0;
          2'h3: pin[i] = 1'b1;
          default: ;
        endcase
        if (full[i] && !tov[i]) pin[i] = 1'b1;
      end
      cf[i] = (act && tk && cnt == a) || (cf[i] && !fclr[i]);
    end
    // last write wins, a write on the wrap cycle counts for that wrap
    for (int q = 0; q < 2; q++) begin
      lk = mode[4*q+1];
      if (vwr[2*q] || !lk) lw[q] = 1'b0;
      if (vwr[2*q+1] && lk) lw[q] = 1'b1;
      if (w) sel[q] = lw[q];
      if (!lk) sel[q] = 1'b0;
    end
    oe = {mode[7:6] == 2'h0 || mode[5], mode[5:4] == 2'h0, mode[3:2] == 2'h0 || mode[1], mode[1:0] == 2'h0};
    wf = w || (wf && !wclr);
    wi = wf && ten;
    ci = cf & ien;
    for (int i = 0; i < 4; i++) if (vwr[i]) v[i] = vdat;
    if (pwr) per = pdat;
    if (tk) cnt = w ? 0 : cnt + 1;
    if (crst) cnt = 0;
  end
  // compare every result but the channel flags while settled
  always @(negedge clk) if (go) begin
    chk("count", 16'(cnt), count_q);
    chk("pin0", 16'(pin[0]), 16'(chan_pin_q[0]));
    chk("pin2", 16'(pin[2]), 16'(chan_pin_q[2]));
    chk("pin13", 16'({pin[3], pin[1]}), 16'({chan_pin_q[3], chan_pin_q[1]}));
    chk("oe_n", 16'(oe), 16'(chan_pin_oe_n_q));
    chk("wrap", 16'(wf), 16'(wrap_flag_q));
    chk("wrap_irq", 16'(wi), 16'(wrap_irq_q));
    chk("chan_irq", 16'(ci), 16'(chan_irq_q));
    chk("lvl", 16'(pin & ~oe), 16'(lvl));
  end
  // hang guard, run needs about 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    go = 1'b1;
    crst = 1'b1;
    @(negedge clk);
    crst = 1'b0;
    pwr = 1'b1;
    pdat = 16'h00ff;
    @(negedge clk);
    pwr = 1'b0;
    for (int i = 0; i < 4; i++) wr(4'h1 << i, rnd());
    mode = {tcmp_pkg::MODE_UNBUF, tcmp_pkg::MODE_UNBUF, tcmp_pkg::MODE_UNBUF, tcmp_pkg::MODE_BUF};
    // odd channels toggle on compare so their pins move while unlinked
    el = {tcmp_pkg::EL_TOGGLE, tcmp_pkg::EL_SET, tcmp_pkg::EL_TOGGLE, tcmp_pkg::EL_CLEAR};
    tov = 4'h5;
    halt = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) mode[5:0] = {tcmp_pkg::MODE_BUF, tcmp_pkg::MODE_UNBUF, 2'h3};
      to_count(10);
      wr(k[0] ? 4'h1 : 4'h2, rnd());
      wr(k[0] ? 4'h4 : 4'h8, rnd());
    end
    tov = 4'h0;
    full = 4'h4;
    to_count(50);
    wclr = 1'b1;
    fclr = 4'hf;
    @(negedge clk);
    wclr = 1'b0;
    fclr = 4'h0;
    to_count(5);
    mode = 8'h55;
    tov = 4'h5;
    full = 4'h0;
    ien = 4'h6;
    ten = 1'b0;
    for (int c = 1; c < 4; c++) begin
      el[1:0] = 2'(c);
      to_count(200);
      wr(4'h1, rnd());
      to_count(5);
    end
    to_count(200);
    print_verdict();
  end
endmodule
`default_nettype wire
